// *** hw/rrc_pkg.sv ***
// constants, types and behaviour list of the redundant reference controller
// Behaviour
// - steer oscillator via synthesiser word of 1.4e-12 step, dithered by fraction
// - with no partner, this controller owns serial, backplane and sync roles
// - backplane role fixed at power-up, slot A holds it by default
// - when A is removed, B takes backplane role and keeps it
// - on master removal slave takes every role; reinsertion gives none back
// - at power-up and user logoff the backplane master takes serial role
// - only serial master drives serial out; serial in always received
// - sync master drives frame sync; outputs follow the sync master
// - alarms and frequency word are always shared with the partner
// - own alarms handled locally; master drives relay and lamps; status sums both
// - dual mode: A uses input A, B uses input B; else shared primary
// - input fault mutes; autoswitch re-acquires other input, resyncs, unmutes
// - returning input with autoreturn brings a switch back, same procedure
// - last to enable syncs to partner first; slave keeps resyncing
// - frequency-degraded ignore keeps outputs unmuted while re-acquiring after an input change; resync still mutes
// - autoswitch off: active input fault squelches outputs
// - autoreturn off: fault of switched-to input squelches outputs
// - switching options user controlled; never switch to an absent input
// - prefer primary input; return to it only with autoreturn
// - keep last 400 events, newest 10 copied to non-volatile store
// - log queries: latest, Nth back, alarms, reports, by controller
// - each alarm change sent as one message with details and time
package rrc_pkg;
  localparam int FREQ_STEP_E12 = 14; // 1.4e-12 per synthesiser lsb, x1e13
  localparam int CLK_HZ        = 25000000;
  localparam int TIME_TICK_MS  = 1000;
  localparam int DITHER_US     = 1000;
  localparam int TICK_CYC      = CLK_HZ / 1000 * TIME_TICK_MS;
  localparam int DITHER_CYC    = CLK_HZ / 1000000 * DITHER_US;
  localparam int LOG_DEPTH     = 400;
  localparam int NV_DEPTH      = 10;
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_ALRM  = 8'h08;
  localparam logic [7:0] A_WORD  = 8'h0C;
  localparam logic [7:0] A_FRAC  = 8'h10;
  localparam logic [7:0] A_EVQ   = 8'h14;
  localparam logic [7:0] A_FORCE = 8'h18;
  localparam int C_ASW = 0, C_ARET = 1, C_UFRC = 2, C_PRIB = 3;
  localparam int C_SHRD = 4, C_IGFD = 5, C_OUTEN = 6, C_LOGIN = 7;
  localparam int C_TAKE = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [1:0] Q_ANY = 2'h0, Q_ALM = 2'h1, Q_REP = 2'h2, Q_SRC = 2'h3;
  localparam logic [5:0] EV_LOSW = 6'h01;
  typedef enum logic [4:0] {
    LO_OFF  = 5'h01,
    LO_RUN  = 5'h02,
    LO_ACQ  = 5'h04,
    LO_SYNC = 5'h08,
    LO_SQL  = 5'h10
  } rrc_lo_e;
  typedef struct packed {
    logic src;
    logic isAlarm;
    logic [5:0] stamp;
    logic [7:0] data;
  } rrc_ev_s;
  typedef struct packed {
    logic [15:0] stamp;
    logic src;
    logic [7:0] alarms;
  } rrc_msg_s;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } rrc_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rrc_axi_rsp_s;
endpackage : rrc_pkg

// *** hw/rrc_top.sv ***
// reference controller mastership, input following, synthesiser and log
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rrc_top #(
  parameter int TICK_CYCLES   = rrc_pkg::TICK_CYC,
  parameter int DITHER_CYCLES = rrc_pkg::DITHER_CYC,
  parameter int LOG_DEPTH     = rrc_pkg::LOG_DEPTH,
  parameter int NV_DEPTH      = rrc_pkg::NV_DEPTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire rrc_pkg::rrc_axi_req_s axiReq,
  output rrc_pkg::rrc_axi_rsp_s      axiRsp,
  input  wire logic                  slotIsB,
  input  wire logic                  peerPresent,
  input  wire logic                  peerSerMaster,
  input  wire logic                  peerOutOn,
  input  wire logic [7:0]            peerAlarms,
  input  wire logic                  loPresentA,
  input  wire logic                  loPresentB,
  input  wire logic                  reacqLock,
  input  wire logic                  syncAligned,
  input  wire logic [7:0]            alarmIn,
  input  wire logic                  serTxIn,
  input  wire logic                  serRxIn,
  output logic                       serTxOut,
  output logic                       serRxOut,
  output logic                       bpMaster,
  output logic                       serMaster,
  output logic                       syncMaster,
  output logic                       frameSyncOut,
  output logic                       slaveResync,
  output logic                       loSelB,
  output logic                       outputOn,
  output logic                       outputMute,
  output logic [31:0]                synthOut,
  output logic [31:0]                shareWord,
  output logic [7:0]                 shareAlarms,
  output logic                       relayOut,
  output logic [7:0]                 lampOut,
  output logic                       msgValid,
  output rrc_pkg::rrc_msg_s          msgOut,
  output logic                       nvWe,
  output logic [3:0]                 nvAddr,
  output logic [15:0]                nvData
);
  // ---------------------------------------------------------------
  // reset and timebase
  // ---------------------------------------------------------------
  logic [1:0]  rstPipe_q;
  logic        rstN;
  logic        started_q;
  logic [24:0] tickCnt_q;
  logic [15:0] dithCnt_q;
  logic        secTick;
  logic        dithTick;
  logic [15:0] stamp_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rstPipe_q <= 2'h0;
    else rstPipe_q <= {rstPipe_q[0], 1'b1};
  end
  assign rstN = rstPipe_q[1];
  assign secTick = (tickCnt_q == 25'(TICK_CYCLES - 1));
  assign dithTick = (dithCnt_q == 16'(DITHER_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      tickCnt_q <= 25'h0;
      dithCnt_q <= 16'h0;
      stamp_q   <= 16'h0;
    end else begin
      tickCnt_q <= secTick ? 25'h0 : tickCnt_q + 25'h1;
      dithCnt_q <= dithTick ? 16'h0 : dithCnt_q + 16'h1;
      if (secTick) stamp_q <= stamp_q + 16'h1;
    end
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic        awHave_q, wHave_q, bvalid_q, rvalid_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q, rData_q, ctrl_q, word_q;
  logic [3:0]  wStrb_q;
  logic [1:0]  bResp_q, rResp_q;
  logic [7:0]  frac_q;
  logic        doWr;
  logic        forceReq_q, forceB_q, takeReq;
  logic        qStart;
  logic [10:0] qCmd_q;
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    return o;
  endfunction : merge
  function automatic logic mapped(input logic [7:0] a);
    return a inside {rrc_pkg::A_CTRL, rrc_pkg::A_STAT, rrc_pkg::A_ALRM, rrc_pkg::A_WORD,
                     rrc_pkg::A_FRAC, rrc_pkg::A_EVQ, rrc_pkg::A_FORCE};
  endfunction : mapped
  assign doWr = awHave_q && wHave_q && !bvalid_q;
  assign takeReq = doWr && awAddr_q == rrc_pkg::A_CTRL && wStrb_q[1] && wData_q[rrc_pkg::C_TAKE];
  assign qStart = doWr && awAddr_q == rrc_pkg::A_EVQ;
  always_comb begin
    axiRsp.awready = !awHave_q;
    axiRsp.wready  = !wHave_q;
    axiRsp.bvalid  = bvalid_q;
    axiRsp.bresp   = bResp_q;
    axiRsp.arready = !rvalid_q;
    axiRsp.rvalid  = rvalid_q;
    axiRsp.rdata   = rData_q;
    axiRsp.rresp   = rResp_q;
  end
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      bvalid_q <= 1'b0;
      awAddr_q <= 8'h0;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
      bResp_q  <= rrc_pkg::RESP_OK;
    end else begin
      if (axiReq.awvalid && !awHave_q) begin
        awHave_q <= 1'b1;
        awAddr_q <= axiReq.awaddr;
      end
      if (axiReq.wvalid && !wHave_q) begin
        wHave_q <= 1'b1;
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
      end
      if (doWr) begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bResp_q  <= mapped(awAddr_q) ? rrc_pkg::RESP_OK : rrc_pkg::RESP_ERR;
      end else if (bvalid_q && axiReq.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  // take flag is a pulse, never stored
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_q     <= rrc_pkg::CTRL_RST;
      word_q     <= 32'h0;
      frac_q     <= 8'h0;
      forceReq_q <= 1'b0;
      forceB_q   <= 1'b0;
      qCmd_q     <= 11'h0;
    end else begin
      forceReq_q <= 1'b0;
      if (doWr) begin
        unique case (awAddr_q)
          rrc_pkg::A_CTRL: ctrl_q <= merge(ctrl_q, wData_q, wStrb_q) & 32'h0000_00FF;
          rrc_pkg::A_WORD: word_q <= merge(word_q, wData_q, wStrb_q);
          rrc_pkg::A_FRAC: if (wStrb_q[0]) frac_q <= wData_q[7:0];
          rrc_pkg::A_EVQ: qCmd_q <= wData_q[10:0];
          rrc_pkg::A_FORCE: begin
            forceReq_q <= 1'b1;
            forceB_q   <= wData_q[0];
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // mastership
  // ---------------------------------------------------------------
  logic peerPrev_q, loginPrev_q, logoff;
  assign logoff = loginPrev_q && !ctrl_q[rrc_pkg::C_LOGIN];
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      started_q  <= 1'b0;
      bpMaster   <= 1'b0;
      serMaster  <= 1'b0;
      peerPrev_q <= 1'b0;
      loginPrev_q <= 1'b0;
    end else begin
      started_q   <= 1'b1;
      peerPrev_q  <= peerPresent;
      loginPrev_q <= ctrl_q[rrc_pkg::C_LOGIN];
      if (!started_q) begin
        bpMaster  <= !slotIsB || !peerPresent;
        serMaster <= !slotIsB || !peerPresent;
      end else if (peerPrev_q && !peerPresent) begin
        bpMaster  <= 1'b1;
        serMaster <= 1'b1;
      end else if (logoff) begin
        serMaster <= bpMaster;
      end else if (takeReq) begin
        serMaster <= 1'b1;
      end else if (peerSerMaster && peerPresent) begin
        serMaster <= 1'b0;
      end
    end
  end
  assign serTxOut = serMaster ? serTxIn : 1'b1;
  assign serRxOut = serRxIn;

  // ---------------------------------------------------------------
  // input following
  // ---------------------------------------------------------------
  rrc_pkg::rrc_lo_e st_q;
  logic home, curOk, othOk, homeOk, mayLeave, ignFd;
  assign home   = ctrl_q[rrc_pkg::C_SHRD] ? ctrl_q[rrc_pkg::C_PRIB] : slotIsB;
  assign curOk  = loSelB ? loPresentB : loPresentA;
  assign othOk  = loSelB ? loPresentA : loPresentB;
  assign homeOk = home ? loPresentB : loPresentA;
  assign ignFd  = ctrl_q[rrc_pkg::C_IGFD];
  // off the home input, a fault only moves on with autoreturn
  assign mayLeave = ctrl_q[rrc_pkg::C_ASW] && othOk && (loSelB == home || ctrl_q[rrc_pkg::C_ARET]);
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      st_q   <= rrc_pkg::LO_OFF;
      loSelB <= 1'b0;
    end else if (!started_q) begin
      loSelB <= home;
    end else begin
      unique case (st_q)
        rrc_pkg::LO_OFF: begin
          if (ctrl_q[rrc_pkg::C_OUTEN] && curOk) st_q <= rrc_pkg::LO_SYNC;
        end
        rrc_pkg::LO_RUN: begin
          if (!ctrl_q[rrc_pkg::C_OUTEN]) st_q <= rrc_pkg::LO_OFF;
          else if (!curOk && mayLeave) begin
            loSelB <= !loSelB;
            st_q   <= rrc_pkg::LO_ACQ;
          end else if (!curOk) st_q <= rrc_pkg::LO_SQL;
          else if (loSelB != home && homeOk && ctrl_q[rrc_pkg::C_ARET]) begin
            loSelB <= home;
            st_q   <= rrc_pkg::LO_ACQ;
          end else if (forceReq_q && ctrl_q[rrc_pkg::C_UFRC] && forceB_q != loSelB && othOk) begin
            loSelB <= forceB_q;
            st_q   <= rrc_pkg::LO_ACQ;
          end
        end
        rrc_pkg::LO_ACQ: begin
          if (!curOk) st_q <= rrc_pkg::LO_SQL;
          else if (reacqLock) st_q <= rrc_pkg::LO_SYNC;
        end
        rrc_pkg::LO_SYNC: begin
          if (!curOk) st_q <= rrc_pkg::LO_SQL;
          else if (syncAligned || !peerOutOn || !peerPresent) st_q <= rrc_pkg::LO_RUN;
        end
        rrc_pkg::LO_SQL: begin
          if (curOk) st_q <= rrc_pkg::LO_ACQ;
          else if (mayLeave) begin
            loSelB <= !loSelB;
            st_q   <= rrc_pkg::LO_ACQ;
          end else if (!ctrl_q[rrc_pkg::C_OUTEN]) st_q <= rrc_pkg::LO_OFF;
        end
      endcase
    end
  end
  assign outputOn   = (st_q == rrc_pkg::LO_RUN) || (ignFd && st_q == rrc_pkg::LO_ACQ);
  assign outputMute = !outputOn;
  assign syncMaster = outputOn && (bpMaster || !peerOutOn || !peerPresent);
  assign frameSyncOut = syncMaster && secTick;
  assign slaveResync = !bpMaster && peerPresent && outputOn;

  // ---------------------------------------------------------------
  // synthesiser dithering and sharing
  // ---------------------------------------------------------------
  logic [8:0] acc_q;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      acc_q    <= 9'h0;
      synthOut <= 32'h0;
    end else if (dithTick) begin
      acc_q    <= {1'b0, acc_q[7:0]} + {1'b0, frac_q};
      synthOut <= word_q + {31'h0, acc_q[8]};
    end
  end
  assign shareWord   = word_q;
  assign shareAlarms = alarmIn;
  assign relayOut = bpMaster && |(alarmIn | peerAlarms);
  assign lampOut  = bpMaster ? (alarmIn | peerAlarms) : 8'h0;

  // ---------------------------------------------------------------
  // alarm messages and event log
  // ---------------------------------------------------------------
  localparam int PW = $clog2(LOG_DEPTH);
  rrc_pkg::rrc_ev_s logMem_q [LOG_DEPTH];
  rrc_pkg::rrc_ev_s newEv;
  logic [7:0] almPrev_q, peerPrev8_q;
  logic       selPrev_q, evValid;
  logic [PW-1:0] wrPtr_q, qIdx_q, qPos;
  logic [PW:0]   count_q;
  logic [8:0]    qHits_q;
  logic          qBusy_q, qFound_q, match;
  logic [15:0]   qData_q;
  always_comb begin
    evValid = 1'b1;
    newEv = '{slotIsB, 1'b1, stamp_q[5:0], alarmIn};
    if (alarmIn != almPrev_q) newEv = '{slotIsB, 1'b1, stamp_q[5:0], alarmIn};
    else if (peerAlarms != peerPrev8_q) newEv = '{!slotIsB, 1'b1, stamp_q[5:0], peerAlarms};
    else if (loSelB != selPrev_q) newEv = '{slotIsB, 1'b0, stamp_q[5:0], {1'b0, loSelB, rrc_pkg::EV_LOSW}};
    else evValid = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      almPrev_q   <= 8'h0;
      peerPrev8_q <= 8'h0;
      selPrev_q   <= 1'b0;
      msgValid    <= 1'b0;
      msgOut      <= '0;
      wrPtr_q     <= '0;
      count_q     <= '0;
      nvWe        <= 1'b0;
      nvAddr      <= 4'h0;
      nvData      <= 16'h0;
    end else begin
      almPrev_q   <= alarmIn;
      peerPrev8_q <= peerAlarms;
      selPrev_q   <= loSelB;
      msgValid    <= started_q && alarmIn != almPrev_q;
      msgOut      <= '{stamp_q, slotIsB, alarmIn};
      nvWe        <= 1'b0;
      if (evValid && started_q) begin
        logMem_q[wrPtr_q] <= newEv;
        wrPtr_q <= (wrPtr_q == PW'(LOG_DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
        if (count_q != (PW+1)'(LOG_DEPTH)) count_q <= count_q + 1'b1;
        nvWe   <= 1'b1;
        nvData <= newEv;
        nvAddr <= (nvAddr == 4'(NV_DEPTH - 1)) ? 4'h0 : nvAddr + 4'h1;
      end
    end
  end
  // walk back from the newest entry, counting matches
  assign qPos = (wrPtr_q > qIdx_q) ? wrPtr_q - qIdx_q - 1'b1 : PW'(LOG_DEPTH) + wrPtr_q - qIdx_q - 1'b1;
  always_comb begin
    unique case (qCmd_q[10:9])
      rrc_pkg::Q_ANY: match = 1'b1;
      rrc_pkg::Q_ALM: match = logMem_q[qPos].isAlarm;
      rrc_pkg::Q_REP: match = !logMem_q[qPos].isAlarm;
      rrc_pkg::Q_SRC: match = logMem_q[qPos].src == qCmd_q[8];
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      qBusy_q  <= 1'b0;
      qFound_q <= 1'b0;
      qIdx_q   <= '0;
      qHits_q  <= 9'h0;
      qData_q  <= 16'h0;
    end else if (qStart) begin
      qBusy_q  <= 1'b1;
      qFound_q <= 1'b0;
      qIdx_q   <= '0;
      qHits_q  <= 9'h0;
    end else if (qBusy_q) begin
      if ((PW+1)'(qIdx_q) >= count_q) qBusy_q <= 1'b0;
      else if (match && qHits_q == {1'b0, qCmd_q[7:0]}) begin
        qBusy_q  <= 1'b0;
        qFound_q <= 1'b1;
        qData_q  <= logMem_q[qPos];
      end else begin
        if (match) qHits_q <= qHits_q + 9'h1;
        qIdx_q <= qIdx_q + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rvalid_q <= 1'b0;
      rData_q  <= 32'h0;
      rResp_q  <= rrc_pkg::RESP_OK;
    end else if (axiReq.arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rResp_q  <= mapped(axiReq.araddr) ? rrc_pkg::RESP_OK : rrc_pkg::RESP_ERR;
      unique case (axiReq.araddr)
        rrc_pkg::A_CTRL: rData_q <= ctrl_q;
        rrc_pkg::A_STAT: rData_q <= {18'h0, loPresentB, loPresentA, st_q, outputMute, loSelB,
                                     slaveResync, syncMaster, serMaster, bpMaster, outputOn};
        rrc_pkg::A_ALRM: rData_q <= {8'h0, alarmIn | peerAlarms, peerAlarms, alarmIn};
        rrc_pkg::A_WORD: rData_q <= word_q;
        rrc_pkg::A_FRAC: rData_q <= {24'h0, frac_q};
        rrc_pkg::A_EVQ: rData_q <= {14'h0, qBusy_q, qFound_q, qData_q};
        default: rData_q <= 32'h0;
      endcase
    end else if (rvalid_q && axiReq.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_bp_sticky: assert property (@(posedge ref_clk) disable iff (!rstN)
    started_q && bpMaster |=> bpMaster) else $error("backplane role dropped");
  a_peer_loss: assert property (@(posedge ref_clk) disable iff (!rstN)
    started_q && $fell(peerPresent) |=> ##1 bpMaster && serMaster) else $error("no takeover");
  a_fault_mute: assert property (@(posedge ref_clk) disable iff (!rstN)
    st_q == rrc_pkg::LO_RUN && !curOk && !ignFd |=> outputMute) else $error("fault not muted");
  a_noauto_sql: assert property (@(posedge ref_clk) disable iff (!rstN)
    st_q == rrc_pkg::LO_RUN && ctrl_q[rrc_pkg::C_OUTEN] && !curOk && !ctrl_q[rrc_pkg::C_ASW]
    |=> st_q == rrc_pkg::LO_SQL && $stable(loSelB)) else $error("no squelch");
  a_sel_present: assert property (@(posedge ref_clk) disable iff (!rstN)
    started_q && $changed(loSelB) |-> (loSelB ? $past(loPresentB) : $past(loPresentA)))
    else $error("switched to absent input");
  a_relay_master: assert property (@(posedge ref_clk) disable iff (!rstN)
    !bpMaster |-> !relayOut && lampOut == 8'h0) else $error("slave drives relay");
  a_alarm_msg: assert property (@(posedge ref_clk) disable iff (!rstN)
    started_q && $changed(alarmIn) |=> msgValid && msgOut.alarms == $past(alarmIn))
    else $error("alarm message missing");
  a_sync_first: assert property (@(posedge ref_clk) disable iff (!rstN)
    $rose(outputOn) && $past(st_q) == rrc_pkg::LO_OFF |-> 1'b0) else $error("enable skipped sync");
  a_tx_gate: assert property (@(posedge ref_clk) disable iff (!rstN)
    !serMaster |-> serTxOut) else $error("non-master drives serial");
endmodule : rrc_top
`default_nettype wire

// *** test/rrc_peer_model.sv ***
// model of the partner reference controller across the backplane
`timescale 1ns/1ps
`default_nettype none
module rrc_peer_model (
  input  wire logic       ref_clk,
  input  wire logic       inserted,
  input  wire logic       outEn,
  input  wire logic [7:0] alarms,
  output logic            peerPresent,
  output logic            peerSerMaster,
  output logic            peerOutOn,
  output logic [7:0]      peerAlarms
);
  logic toggle_q = 1'b0;
  logic pulled_q = 1'b0;
  // a removed card leaves its lines changing every cycle
  always_ff @(posedge ref_clk) toggle_q <= ~toggle_q;
  always_ff @(posedge ref_clk) pulled_q <= pulled_q | ~inserted;
  assign peerPresent   = inserted;
  assign peerSerMaster = inserted ? ~pulled_q : toggle_q;
  assign peerOutOn     = inserted ? outEn : toggle_q;
  assign peerAlarms    = inserted ? alarms : {8{toggle_q}};
endmodule : rrc_peer_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking testbench for the reference controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
  logic ref_clk = 1'b0, reset_n = 1'b0, slotIsB = 1'b1, inserted = 1'b1, peerEn = 1'b0;
  logic loPresentA = 1'b1, loPresentB = 1'b1, reacqLock = 1'b0, syncAligned = 1'b0;
  logic serTxIn = 1'b0, serRxIn = 1'b1;
  logic [7:0] alarmIn = 8'h03;
  logic peerPresent, peerSerMaster, peerOutOn, serTxOut, serRxOut, bpMaster, serMaster;
  logic loSelB, outputOn, outputMute, msgValid;
  rrc_pkg::rrc_msg_s msgOut;
  logic [7:0] peerAlarms, shareAlarms, lampOut;
  rrc_pkg::rrc_axi_req_s req = '0;
  rrc_pkg::rrc_axi_rsp_s rsp;
  int miscompares = 0, samplesChecked = 0;
  always #20 ref_clk = ~ref_clk;
  rrc_peer_model peer (.ref_clk(ref_clk), .inserted(inserted), .outEn(peerEn), .alarms(8'h50),
    .peerPresent(peerPresent), .peerSerMaster(peerSerMaster), .peerOutOn(peerOutOn), .peerAlarms(peerAlarms));
  rrc_top #(.TICK_CYCLES(50), .DITHER_CYCLES(8), .LOG_DEPTH(16)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .axiReq(req), .axiRsp(rsp), .slotIsB(slotIsB), .peerPresent(peerPresent), .peerSerMaster(peerSerMaster),
    .peerOutOn(peerOutOn), .peerAlarms(peerAlarms), .loPresentA(loPresentA), .loPresentB(loPresentB),
    .reacqLock(reacqLock), .syncAligned(syncAligned), .alarmIn(alarmIn), .serTxIn(serTxIn), .serRxIn(serRxIn),
    .serTxOut(serTxOut), .serRxOut(serRxOut), .bpMaster(bpMaster), .serMaster(serMaster), .syncMaster(),
    .frameSyncOut(), .slaveResync(), .loSelB(loSelB), .outputOn(outputOn), .outputMute(outputMute),
    .synthOut(), .shareWord(), .shareAlarms(shareAlarms), .relayOut(), .lampOut(lampOut), .msgValid(msgValid),
    .msgOut(msgOut), .nvWe(), .nvAddr(), .nvData());
  // ----------------------------------------
  // register bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1, default: '0};
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while ((req.awvalid && !rsp.awready) || (req.wvalid && !rsp.wready));
    do @(posedge ref_clk); while (!rsp.bvalid);
    `CHK("bresp", rrc_pkg::RESP_OK, rsp.bresp)
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do @(posedge ref_clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge ref_clk);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    settle(5);
    rd(rrc_pkg::A_CTRL, d, r);
    `CHK("ctrl", rrc_pkg::CTRL_RST, d)
    rd(rrc_pkg::A_ALRM, d, r);
    `CHK("alarms", 32'h0053_5003, d)
    rd(8'h40, d, r);
    `CHK("unmapped", rrc_pkg::RESP_ERR, r)
    `CHK("bpMaster", 1'b0, bpMaster)
    `CHK("serMaster", 1'b0, serMaster)
    `CHK("serTxOut", 1'b1, serTxOut)
    `CHK("serRxOut", 1'b1, serRxOut)
    `CHK("lampOut", 8'h00, lampOut)
    `CHK("shareAlarms", 8'h03, shareAlarms)
    `CHK("loSelB", 1'b1, loSelB)
    peerEn <= 1'b1;
    wr(rrc_pkg::A_CTRL, 32'h0000_0043);
    settle(4);
    `CHK("waitSync", 1'b1, outputMute)
    @(posedge ref_clk);
    syncAligned <= 1'b1;
    settle(4);
    `CHK("synced", 1'b1, outputOn)
    @(posedge ref_clk);
    loPresentB <= 1'b0;
    settle(3);
    `CHK("switchSel", 1'b0, loSelB)
    `CHK("switchOn", 1'b0, outputOn)
    @(posedge ref_clk);
    reacqLock <= 1'b1;
    settle(5);
    `CHK("reacquired", 1'b1, outputOn)
    @(posedge ref_clk);
    loPresentB <= 1'b1;
    settle(6);
    `CHK("returnSel", 1'b1, loSelB)
    `CHK("returnOn", 1'b1, outputOn)
    wr(rrc_pkg::A_CTRL, 32'h0000_0042);
    @(posedge ref_clk);
    loPresentB <= 1'b0;
    settle(4);
    rd(rrc_pkg::A_STAT, d, r);
    `CHK("squelch", 5'h10, d[11:7])
    @(posedge ref_clk);
    inserted <= 1'b0;
    settle(4);
    `CHK("takeBp", 1'b1, bpMaster)
    `CHK("takeSer", 1'b1, serMaster)
    `CHK("txDriven", 1'b0, serTxOut)
    @(posedge ref_clk);
    inserted <= 1'b1;
    settle(4);
    `CHK("keepBp", 1'b1, bpMaster)
    `CHK("keepSer", 1'b1, serMaster)
    @(posedge ref_clk);
    alarmIn <= 8'h07;
    @(posedge ref_clk);
    #1;
    `CHK("msgValid", 1'b1, msgValid)
    `CHK("msgAlarms", 8'h07, msgOut.alarms)
    wr(rrc_pkg::A_EVQ, 32'h0000_0000);
    settle(4);
    rd(rrc_pkg::A_EVQ, d, r);
    `CHK("evqFound", 2'b01, d[17:16])
    `CHK("evqEntry", 2'b11, d[15:14])
    `CHK("evqData", 8'h07, d[7:0])
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
